// >>> threshold_trigger_logic.sv
// threshold_trigger_logic: frequency, analog and differential threshold triggers
// assumes APB from a synchronous master and analog samples synchronous to clk_sys
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module threshold_trigger_logic #(
    parameter int GATE_UNIT_CYC = trig_pkg::GATE_UNIT_CYC,
    parameter int AN_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register bus
    input wire trig_pkg::apb_req_s apb_req,
    output var trig_pkg::apb_rsp_s apb_rsp,
    // pulse and analog sources
    input wire logic fast_input_one,
    input wire logic fast_input_two,
    input wire logic slow_input,
    input wire logic signed [AN_W-1:0] analog_input,
    // switching outputs
    output logic freq_q_r,
    output logic ana_q_r,
    output logic diff_q_r
);
    import trig_pkg::*;

    logic [CTRL_SEL_W-1:0] sel_r;
    logic [GATE_W-1:0] freq_on_r;
    logic [GATE_W-1:0] freq_off_r;
    logic [GATE_W-1:0] gate_len_r;
    logic signed [31:0] gain_r;
    logic signed [31:0] offset_r;
    logic signed [31:0] ana_on_r;
    logic signed [31:0] ana_off_r;
    logic signed [31:0] diff_on_r;
    logic signed [31:0] diff_delta_r;
    logic [DEC_W-1:0] decimals_r;
    logic signed [31:0] actual_r;
    logic signed [31:0] diff_off_r;
    logic signed [31:0] actual_nxt;
    logic [CNT_W-1:0] count;
    logic gate_done;
    logic pulse_sel;
    logic access;
    logic wr_en;
    logic signed [31:0] wdata;
    logic [31:0] rd_mux;

    // ============================================================
    // shared decoding
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input int lo, input int hi);
        if (v < lo) begin
            return 32'(lo);
        end else if (v > hi) begin
            return 32'(hi);
        end
        return v;
    endfunction

    function automatic logic hyst(input logic q, input logic signed [31:0] v,
                                  input logic signed [31:0] on,
                                  input logic signed [31:0] off);
        if (on >= off) begin
            if (v > on) begin
                return 1'b1;
            end else if (v <= off) begin
                return 1'b0;
            end
            return q;
        end
        return (v >= on) && (v < off);
    endfunction

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_DIFF_OFF);
    endfunction

    // ============================================================
    // APB slave, one wait state
    assign access = apb_req.psel & apb_req.penable;
    assign wr_en = access & apb_req.pwrite & apb_rsp.pready;
    assign wdata = $signed(apb_req.pwdata);

    always_comb begin
        rd_mux = 32'h0;
        case (apb_req.paddr)
            OFS_CTRL: rd_mux = 32'(sel_r);
            OFS_FREQ_ON: rd_mux = 32'(freq_on_r);
            OFS_FREQ_OFF: rd_mux = 32'(freq_off_r);
            OFS_GATE: rd_mux = 32'(gate_len_r);
            OFS_GAIN: rd_mux = gain_r;
            OFS_OFFSET: rd_mux = offset_r;
            OFS_ANA_ON: rd_mux = ana_on_r;
            OFS_ANA_OFF: rd_mux = ana_off_r;
            OFS_DIFF_ON: rd_mux = diff_on_r;
            OFS_DIFF_DELTA: rd_mux = diff_delta_r;
            OFS_DECIMALS: rd_mux = 32'(decimals_r);
            OFS_STATUS: rd_mux = {29'h0, diff_q_r, ana_q_r, freq_q_r};
            OFS_FREQ_VAL: rd_mux = 32'(count);
            OFS_ANA_ACT: rd_mux = actual_r;
            OFS_DIFF_OFF: rd_mux = diff_off_r;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready <= access & ~apb_rsp.pready;
            if (access && !apb_rsp.pready) begin
                apb_rsp.prdata <= apb_req.pwrite ? 32'h0 : rd_mux;
                apb_rsp.pslverr <= ~reg_mapped(apb_req.paddr);
            end else begin
                apb_rsp.prdata <= 32'h0;
                apb_rsp.pslverr <= 1'b0;
            end
        end
    end

    // ============================================================
    // configuration registers, written values forced into range
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sel_r <= SEL_FAST_ONE;
            freq_on_r <= '0;
            freq_off_r <= '0;
            gate_len_r <= GATE_RST;
            gain_r <= GAIN_RST;
            offset_r <= '0;
            ana_on_r <= '0;
            ana_off_r <= '0;
            diff_on_r <= '0;
            diff_delta_r <= '0;
            decimals_r <= '0;
        end else if (wr_en) begin
            case (apb_req.paddr)
                OFS_CTRL: sel_r <= apb_req.pwdata[CTRL_SEL_LSB +: CTRL_SEL_W];
                OFS_FREQ_ON: freq_on_r <= GATE_W'(clamp(wdata, 0, FREQ_THR_MAX));
                OFS_FREQ_OFF: freq_off_r <= GATE_W'(clamp(wdata, 0, FREQ_THR_MAX));
                OFS_GATE: gate_len_r <= GATE_W'(clamp(wdata, GATE_MIN, GATE_MAX));
                OFS_GAIN: gain_r <= clamp(wdata, 0, GAIN_MAX);
                OFS_OFFSET: offset_r <= clamp(wdata, -OFFSET_LIM, OFFSET_LIM);
                OFS_ANA_ON: ana_on_r <= clamp(wdata, -THR_LIM, THR_LIM);
                OFS_ANA_OFF: ana_off_r <= clamp(wdata, -THR_LIM, THR_LIM);
                OFS_DIFF_ON: diff_on_r <= clamp(wdata, -THR_LIM, THR_LIM);
                OFS_DIFF_DELTA: diff_delta_r <= clamp(wdata, -THR_LIM, THR_LIM);
                OFS_DECIMALS: decimals_r <= apb_req.pwdata[DEC_W-1:0];
                default: ;
            endcase
        end
    end

    // ============================================================
    // frequency trigger
    always_comb begin
        case (sel_r)
            SEL_FAST_ONE: pulse_sel = fast_input_one;
            SEL_FAST_TWO: pulse_sel = fast_input_two;
            SEL_SLOW: pulse_sel = slow_input;
            default: pulse_sel = slow_input;
        endcase
    end

    pulse_gate_counter #(
        .CNT_W(CNT_W),
        .GATE_W(GATE_W),
        .TICK_CYC(GATE_UNIT_CYC)
    ) u_gate (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pulse_in(pulse_sel),
        .gate_len(gate_len_r),
        .count_r(count),
        .done_r(gate_done)
    );

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            freq_q_r <= 1'b0;
        end else if (gate_done) begin
            freq_q_r <= hyst(freq_q_r, 32'(count), 32'(freq_on_r), 32'(freq_off_r));
        end
    end

    // ============================================================
    // analog and differential triggers, raw integers only
    assign actual_nxt = (32'(analog_input) * gain_r) / GAIN_DIV + offset_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            actual_r <= '0;
            diff_off_r <= '0;
        end else begin
            actual_r <= actual_nxt;
            diff_off_r <= diff_on_r + diff_delta_r;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ana_q_r <= 1'b0;
            diff_q_r <= 1'b0;
        end else begin
            ana_q_r <= hyst(ana_q_r, actual_r, ana_on_r, ana_off_r);
            diff_q_r <= hyst(diff_q_r, actual_r, diff_on_r, diff_off_r);
        end
    end

    // ============================================================
    // checks
    property p_freq_only_at_gate;
        @(posedge clk_sys) disable iff (!reset_n)
        !gate_done |=> $stable(freq_q_r);
    endproperty
    a_freq_only_at_gate: assert property (p_freq_only_at_gate)
        else $error("frequency output moved between gates");

    property p_freq_hyst_set;
        @(posedge clk_sys) disable iff (!reset_n)
        gate_done && freq_on_r >= freq_off_r && 32'(count) > 32'(freq_on_r) |=> freq_q_r;
    endproperty
    a_freq_hyst_set: assert property (p_freq_hyst_set)
        else $error("frequency output not set above on threshold");

    property p_freq_window;
        @(posedge clk_sys) disable iff (!reset_n)
        gate_done && freq_on_r < freq_off_r |=>
            freq_q_r == ($past(count) >= CNT_W'($past(freq_on_r))
                         && $past(count) < CNT_W'($past(freq_off_r)));
    endproperty
    a_freq_window: assert property (p_freq_window)
        else $error("frequency window result wrong");

    property p_gate_in_range;
        @(posedge clk_sys) disable iff (!reset_n)
        gate_len_r >= GATE_W'(GATE_MIN) && gate_len_r <= GATE_W'(GATE_MAX)
            && freq_on_r <= GATE_W'(FREQ_THR_MAX);
    endproperty
    a_gate_in_range: assert property (p_gate_in_range)
        else $error("gate or threshold outside range");

    property p_analog_ranges;
        @(posedge clk_sys) disable iff (!reset_n)
        gain_r >= 0 && gain_r <= GAIN_MAX && offset_r <= OFFSET_LIM
            && offset_r >= -OFFSET_LIM && ana_on_r <= THR_LIM && ana_off_r >= -THR_LIM;
    endproperty
    a_analog_ranges: assert property (p_analog_ranges)
        else $error("analog parameter outside range");

    property p_actual_value;
        @(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> actual_r == (32'($past(analog_input)) * $past(gain_r)) / GAIN_DIV
                             + $past(offset_r);
    endproperty
    a_actual_value: assert property (p_actual_value)
        else $error("actual value is not input times gain plus offset");

    sequence s_ana_above;
        ana_on_r >= ana_off_r && actual_r > ana_on_r;
    endsequence
    sequence s_ana_below;
        ana_on_r >= ana_off_r && actual_r <= ana_off_r;
    endsequence
    property p_ana_hyst;
        @(posedge clk_sys) disable iff (!reset_n)
        (s_ana_above |=> ana_q_r) and (s_ana_below |=> !ana_q_r);
    endproperty
    a_ana_hyst: assert property (p_ana_hyst)
        else $error("analog hysteresis result wrong");

    property p_ana_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        ana_on_r >= ana_off_r && actual_r > ana_off_r && actual_r <= ana_on_r
            |=> ana_q_r == $past(ana_q_r);
    endproperty
    a_ana_hold: assert property (p_ana_hold)
        else $error("analog output left its state inside the band");

    property p_diff_off;
        @(posedge clk_sys) disable iff (!reset_n)
        $stable(diff_on_r) && $stable(diff_delta_r) |=>
            diff_off_r == $past(diff_on_r) + $past(diff_delta_r);
    endproperty
    a_diff_off: assert property (p_diff_off)
        else $error("differential off threshold not on plus delta");

    property p_decimals_ignored;
        @(posedge clk_sys) disable iff (!reset_n)
        wr_en && apb_req.paddr == OFS_DECIMALS && $stable(analog_input) |=> $stable(actual_r);
    endproperty
    a_decimals_ignored: assert property (p_decimals_ignored)
        else $error("decimals setting changed the compared value");
endmodule
`default_nettype wire

// >>> trig_pkg.sv
// trig_pkg: register map, field layout, ranges and timing for the trigger block
// assumes a 250 MHz system clock and an APB master with 32-bit data
// ============================================================
// Notes on behaviour
// - count only rising edges of pulse input
// - gate 00:05 to 99:99 s, thresholds 0..9999
// - frequency hysteresis or window comparison
// - compare once per gate, on finished count
// - value is total pulses in one gate
// - gate time base fixed to seconds
// - actual value is input times gain plus offset
// - analog hysteresis or window comparison
// - decimals only for display, not comparison
// - differential off equals on plus delta
package trig_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 18;
    localparam int GATE_W = 14;
    // ============================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ_ON = 8'h04;
    localparam logic [7:0] OFS_FREQ_OFF = 8'h08;
    localparam logic [7:0] OFS_GATE = 8'h0c;
    localparam logic [7:0] OFS_GAIN = 8'h10;
    localparam logic [7:0] OFS_OFFSET = 8'h14;
    localparam logic [7:0] OFS_ANA_ON = 8'h18;
    localparam logic [7:0] OFS_ANA_OFF = 8'h1c;
    localparam logic [7:0] OFS_DIFF_ON = 8'h20;
    localparam logic [7:0] OFS_DIFF_DELTA = 8'h24;
    localparam logic [7:0] OFS_DECIMALS = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_FREQ_VAL = 8'h30;
    localparam logic [7:0] OFS_ANA_ACT = 8'h34;
    localparam logic [7:0] OFS_DIFF_OFF = 8'h38;
    // ============================================================
    // fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_W = 2;
    localparam logic [1:0] SEL_FAST_ONE = 2'h0;
    localparam logic [1:0] SEL_FAST_TWO = 2'h1;
    localparam logic [1:0] SEL_SLOW = 2'h2;
    localparam int DEC_W = 2;
    // ============================================================
    // ranges, raw integers with the decimal point dropped
    localparam int FREQ_THR_MAX = 9999;
    localparam int GATE_MIN = 5;
    localparam int GATE_MAX = 9999;
    localparam int GAIN_MAX = 1000;
    localparam int GAIN_DIV = 100;
    localparam int OFFSET_LIM = 10000;
    localparam int THR_LIM = 20000;
    // ============================================================
    // reset values
    localparam logic [GATE_W-1:0] GATE_RST = 14'h0064;
    localparam logic signed [31:0] GAIN_RST = 32'sh0000_0064;
    // ============================================================
    // timing: gate unit is one hundredth of a second
    localparam int CLK_MHZ = 250;
    localparam int GATE_UNIT_MS = 10;
    localparam int GATE_UNIT_CYC = CLK_MHZ * 1000 * GATE_UNIT_MS;
    // ============================================================
    // bus carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;
endpackage

// >>> pulse_gate_counter.sv
// pulse_gate_counter: synchroniser, rising edge detect and gated pulse count
// assumes gate_len is a count of gate units, never below one
`timescale 1ns/1ns
`default_nettype none
module pulse_gate_counter #(
    parameter int CNT_W = 18,
    parameter int GATE_W = 14,
    parameter int TICK_CYC = 2500000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // pulse and gate length
    input wire logic pulse_in,
    input wire logic [GATE_W-1:0] gate_len,
    // result
    output logic [CNT_W-1:0] count_r,
    output logic done_r
);
    logic [1:0] sync_r;
    logic prev_r;
    logic [31:0] tick_r;
    logic [GATE_W-1:0] units_r;
    logic [CNT_W-1:0] acc_r;
    logic rise;
    logic tick;
    logic gate_end;
    logic acc_full;

    // ============================================================
    // synchroniser and edge detect
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_r <= 2'h0;
            prev_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[0], pulse_in};
            prev_r <= sync_r[1];
        end
    end
    assign rise = sync_r[1] & ~prev_r;

    // ============================================================
    // gate timing in fixed second-based units
    assign tick = (tick_r == 32'(TICK_CYC - 1));
    assign gate_end = tick && (units_r >= gate_len - 14'h0001);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tick_r <= 32'h0;
            units_r <= '0;
        end else begin
            tick_r <= tick ? 32'h0 : tick_r + 32'h1;
            if (gate_end) begin
                units_r <= '0;
            end else if (tick) begin
                units_r <= units_r + 14'h0001;
            end
        end
    end

    // ============================================================
    // pulse accumulation
    assign acc_full = &acc_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= '0;
            count_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= gate_end;
            if (gate_end) begin
                count_r <= acc_full ? acc_r : acc_r + CNT_W'(rise);
                acc_r <= '0;
            end else if (rise && !acc_full) begin
                acc_r <= acc_r + 1'b1;
            end
        end
    end

    property p_rise_counts_once;
        @(posedge clk_sys) disable iff (!reset_n)
        rise && !gate_end && !acc_full |=> acc_r == $past(acc_r) + 1'b1 && !rise;
    endproperty
    a_rise_counts_once: assert property (p_rise_counts_once)
        else $error("rising edge not counted exactly once");

    property p_fall_ignored;
        @(posedge clk_sys) disable iff (!reset_n)
        !rise && !gate_end |=> acc_r == $past(acc_r);
    endproperty
    a_fall_ignored: assert property (p_fall_ignored)
        else $error("count moved without a rising edge");

    property p_gate_total;
        @(posedge clk_sys) disable iff (!reset_n)
        gate_end && !acc_full |=> done_r && count_r == $past(acc_r) + CNT_W'($past(rise));
    endproperty
    a_gate_total: assert property (p_gate_total)
        else $error("gate result differs from pulses accumulated");
endmodule
`default_nettype wire

// >>> trig_source_model.sv
// trig_source_model: pulse sources and analog channel feeding the trigger block
// assumes a free running clk_sys; analog value comes from the bench
`timescale 1ns/1ns
`default_nettype none
module trig_source_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // analog value wanted
    input wire logic signed [15:0] ana_set,
    // sources
    output logic fast_one,
    output logic fast_two,
    output logic slow,
    output logic signed [15:0] analog
);
    // ============================================================
    // periods 10, 25 and 50 cycles: 5, 2, 1 rises per 50-cycle gate
    logic [5:0] phase_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= 6'h00;
            fast_one <= 1'b0;
            fast_two <= 1'b0;
            slow <= 1'b0;
        end else begin
            phase_r <= (phase_r == 6'h31) ? 6'h00 : phase_r + 6'h01;
            fast_one <= (phase_r % 10) < 5;
            fast_two <= (phase_r % 25) < 12;
            slow <= phase_r < 6'h19;
        end
    end
    // ============================================================
    always_ff @(posedge clk_sys) begin
        analog <= ana_set;
    end
endmodule
`default_nettype wire

// >>> threshold_trigger_logic_tb.sv
// threshold_trigger_logic_tb: self-checking bench for the trigger block
// assumes trig_pkg and the source model; gate unit shortened to 10 cycles
`timescale 1ns/1ns
`default_nettype none
module threshold_trigger_logic_tb;
    import trig_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    apb_req_s apb_req = '0;
    apb_rsp_s apb_rsp;
    logic f1, f2, sl, fq, aq, dq;
    logic signed [15:0] ana;
    logic signed [15:0] ana_set = 16'sh0000;
    int fail_count = 0;
    int n_checks = 0;
    logic [32:0] expq[$];
    logic [31:0] rng = 32'h0000_0051;
    int ons[4] = '{3, 9, 9, 4};
    int offs[4] = '{1, 4, 7, 6};
    logic exps[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    int cnts[4] = '{5, 2, 1, 1};
    int act;
    int doff;
    logic pa, pd;
    always #2 clk_sys = ~clk_sys;
    threshold_trigger_logic #(.GATE_UNIT_CYC(10), .AN_W(16)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .fast_input_one(f1), .fast_input_two(f2), .slow_input(sl), .analog_input(ana),
        .freq_q_r(fq), .ana_q_r(aq), .diff_q_r(dq));
    trig_source_model src (.clk_sys(clk_sys), .reset_n(reset_n), .ana_set(ana_set),
        .fast_one(f1), .fast_two(f2), .slow(sl), .analog(ana));
    // ============================================================
    // compare and report
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check_rd(input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic check_q(input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    function automatic logic hyst(input logic prev, input int v, input int on, input int off);
        if (on >= off) begin
            return (v > on) ? 1'b1 : ((v <= off) ? 1'b0 : prev);
        end
        return (v >= on) && (v < off);
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // ============================================================
    // bus master, reads note their expectation
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= is_wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        if (!is_wr) begin
            expq.push_back(e);
        end
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask
    // ============================================================
    // monitor takes the oldest note at each read answer
    always @(posedge clk_sys) begin
        if (apb_rsp.pready === 1'b1 && apb_req.pwrite === 1'b0 && expq.size() > 0) begin
            check_rd(expq.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata});
        end
    end
    // ============================================================
    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_GATE, 32'd100);
        rd(OFS_GAIN, 32'd100);
        apb(1'b0, 8'h3c, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 8'h02, 32'h0, {1'b1, 32'h0});
        wr(OFS_GATE, 32'd1);
        rd(OFS_GATE, 32'd5);
        wr(OFS_FREQ_ON, 32'd20000);
        rd(OFS_FREQ_ON, 32'd9999);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_FREQ_ON, ons[i]);
            wr(OFS_FREQ_OFF, offs[i]);
            repeat (160) @(posedge clk_sys);
            check_q(exps[i], fq);
        end
        rd(OFS_FREQ_VAL, 32'd5);
        for (int s = 3; s >= 0; s--) begin
            wr(OFS_CTRL, s);
            repeat (160) @(posedge clk_sys);
            rd(OFS_FREQ_VAL, cnts[s]);
        end
        wr(OFS_GAIN, 32'd250);
        wr(OFS_OFFSET, -32'sd300);
        wr(OFS_ANA_ON, 32'd500);
        wr(OFS_ANA_OFF, -32'sd200);
        wr(OFS_DIFF_ON, 32'd100);
        wr(OFS_DIFF_DELTA, 32'd300);
        wr(OFS_DECIMALS, 32'd3);
        rd(OFS_DECIMALS, 32'd3);
        rd(OFS_DIFF_OFF, 32'd400);
        pa = 1'b0;
        pd = 1'b0;
        doff = 400;
        for (int k = 0; k < 24; k++) begin
            if (k == 12) begin
                wr(OFS_DIFF_DELTA, -32'sd300);
                rd(OFS_DIFF_OFF, -32'sd200);
                doff = -200;
                pd = hyst(pd, act, 100, doff);
            end
            rng = xs(rng);
            ana_set <= $signed(rng[10:0]);
            repeat (4) @(posedge clk_sys);
            act = int'(ana_set) * 250 / 100 - 300;
            pa = hyst(pa, act, 500, -200);
            pd = hyst(pd, act, 100, doff);
            check_q(pa, aq);
            check_q(pd, dq);
            rd(OFS_ANA_ACT, act);
        end
        final_report();
    end
endmodule
`default_nettype wire
